// ===== rtl/scan_adc_ctrl.sv
// Purpose: Mode control, scan sequencer and serial front end.
// Assumes: Start and serial pins are sampled by the block clock through two flip-flops.
// Notes:   Received bytes pass through a small FIFO to the user side.
`timescale 1ns/1ps
module byte_fifo #(
    parameter int width = 9,
    parameter int depth = 4
) (
    input  wire logic             mclk_in,
    input  wire logic             resetn_in,
    input  wire logic             in_valid_in,
    output      logic             in_ready_out,
    input  wire logic [width-1:0] in_data_in,
    output      logic             out_valid_out,
    input  wire logic             out_ready_in,
    output      logic [width-1:0] out_data_out
);
    localparam int AW = (depth > 1) ? $clog2(depth) : 1;
    localparam logic [AW:0]   FULL = (AW+1)'(depth);
    localparam logic [AW-1:0] LAST = AW'(depth - 1);
    logic [width-1:0] mem [depth];
    logic [AW-1:0]    wr;
    logic [AW-1:0]    rd;
    logic [AW-1:0]    next_wr;
    logic [AW-1:0]    next_rd;
    logic [AW:0]      cnt;
    logic [AW:0]      next_cnt;
    logic             push;
    logic             pop;
    assign in_ready_out  = (cnt != FULL);
    assign out_valid_out = (cnt != '0);
    assign out_data_out  = mem[rd];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;
    always_comb begin
        next_wr  = wr;
        next_rd  = rd;
        next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (push) begin
            next_wr = (wr == LAST) ? '0 : wr + 1'b1;
        end
        if (pop) begin
            next_rd = (rd == LAST) ? '0 : rd + 1'b1;
        end
    end
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr  <= '0;
            rd  <= '0;
            cnt <= '0;
        end else begin
            wr  <= next_wr;
            rd  <= next_rd;
            cnt <= next_cnt;
        end
    end
    always_ff @(posedge mclk_in) begin
        if (push) begin
            mem[wr] <= in_data_in;
        end
    end
endmodule

module scan_adc_ctrl import scan_adc_pkg::*; #(
    parameter logic [13:0] slow_fixed_cycles = 14'h22a2,
    parameter logic [13:0] slow_scan_cycles  = 14'h2244,
    parameter logic [13:0] cont_cycles       = 14'h0100,
    parameter logic [7:0]  pulse_opcode      = 8'h80,
    parameter int          fifo_depth        = 4
) (
    input  wire logic       mclk_in,
    input  wire logic       resetn_in,
    input  wire logic       start_in,
    input  wire logic       power_down_in,
    input  wire logic       scan_mode_select_in,
    input  wire logic       idle_mode_select_in,
    input  wire logic       interface_timeout_select_in,
    input  wire logic [1:0] rate_code_in,
    input  wire logic [7:0] differential_select_register_in,
    input  wire logic [7:0] single_ended_select_low_in,
    input  wire logic [7:0] single_ended_select_high_in,
    input  wire logic [4:0] system_measure_select_in,
    input  wire logic       select_write_in,
    input  wire logic [3:0] fixed_pos_in,
    input  wire logic [3:0] fixed_neg_in,
    input  wire logic       cs_n_in,
    input  wire logic       sclk_in,
    input  wire logic       din_in,
    input  wire logic [7:0] tx_byte_in,
    input  wire logic       rx_ready_in,
    output      logic       dout_out,
    output      logic       dout_oe_n_out,
    output      logic       data_ready_n_out,
    output      logic       converting_out,
    output      logic       standby_out,
    output      logic       sleep_out,
    output      logic       analog_enable_out,
    output      logic [4:0] channel_out,
    output      logic [4:0] mux_pos_out,
    output      logic [4:0] mux_neg_out,
    output      logic [7:0] rx_byte_out,
    output      logic       rx_command_out,
    output      logic       rx_valid_out,
    output      logic       rx_stall_out
);
    logic [3:0]   sync_a;
    logic [3:0]   sync_b;
    logic         sclk_d;
    logic         start_s, cs_s, sclk_s, din_s;
    logic         rise, fall, spi_reset, timeout_hit, byte_done;
    logic         pulse_hit, fifo_ready, done;
    logic [12:0]  limit;
    logic [2:0]   bit_cnt, next_bit_cnt;
    logic [6:0]   rx_sh, next_rx_sh;
    logic [7:0]   tx_sh, next_tx_sh;
    logic         first_byte, next_first_byte;
    logic [12:0]  idle_cnt, next_idle_cnt;
    op_state_t    state, next_state;
    logic [4:0]   ptr, next_ptr, first_sel;
    logic [13:0]  cnt, next_cnt;
    logic         single, next_single;
    logic         sleep_wake, next_sleep_wake;
    logic [3:0]   ready_cnt, next_ready_cnt;
    logic [4:0]   next_mux_pos, next_mux_neg;
    logic [28:0]  sel_mask;
    logic [8:0]   fifo_out;

    assign {start_s, cs_s, sclk_s, din_s} = sync_b;
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync_a <= SYNC_RST;
            sync_b <= SYNC_RST;
            sclk_d <= 1'b0;
        end else begin
            sync_a <= {start_in, cs_n_in, sclk_in, din_in};
            sync_b <= sync_a;
            sclk_d <= sclk_s;
        end
    end

    // Next selected entry after p in list order, wrapping to the top.
    function automatic logic [4:0] next_sel(input logic [28:0] m,
                                            input logic [4:0]  p);
        logic [4:0] r;
        logic       found;
        int         i;
        r     = p;
        found = 1'b0;
        for (int k = 1; k <= NUM_CH; k++) begin
            i = (int'(p) + k) % NUM_CH;
            if (!found && m[i]) begin
                r     = 5'(i);
                found = 1'b1;
            end
        end
        return r;
    endfunction

    function automatic logic [13:0] first_delay(input logic [1:0] rate,
                                                input logic       scan,
                                                input logic       slp);
        logic [13:0] d;
        case (rate)
            RATE_FAST: d = scan ? SCAN_R3 : FIX_R3;
            RATE_MID:  d = scan ? SCAN_R2 : FIX_R2;
            RATE_LOW:  d = scan ? SCAN_R1 : FIX_R1;
            default:   d = scan ? slow_scan_cycles : slow_fixed_cycles;
        endcase
        return slp ? d + SLEEP_EXTRA : d;
    endfunction

    // Serial front end.
    assign rise        = sclk_s && !sclk_d;
    assign fall        = !sclk_s && sclk_d;
    assign limit       = interface_timeout_select_in ? TMO_SHORT : TMO_LONG;
    assign timeout_hit = !rise && !fall && (idle_cnt == limit - 1'b1);
    assign spi_reset   = cs_s || timeout_hit || (state == st_power_down);
    assign byte_done   = rise && (bit_cnt == BYTE_LAST) && !spi_reset;
    assign pulse_hit   = byte_done && first_byte &&
                         ({rx_sh, din_s} == pulse_opcode);
    always_comb begin
        next_bit_cnt    = bit_cnt;
        next_rx_sh      = rx_sh;
        next_tx_sh      = tx_sh;
        next_first_byte = first_byte;
        next_idle_cnt   = idle_cnt + 1'b1;
        if (rise || fall || cs_s || timeout_hit) begin
            next_idle_cnt = '0;
        end
        if (spi_reset) begin
            next_bit_cnt    = '0;
            next_first_byte = 1'b1;
            next_tx_sh      = tx_byte_in;
        end else begin
            if (rise) begin
                next_rx_sh   = {rx_sh[5:0], din_s};
                next_bit_cnt = bit_cnt + 1'b1;
                if (byte_done) begin
                    next_first_byte = 1'b0;
                end
            end
            if (fall) begin
                next_tx_sh = (bit_cnt == '0) ? tx_byte_in
                                             : {tx_sh[6:0], 1'b0};
            end
        end
    end
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bit_cnt    <= '0;
            rx_sh      <= '0;
            tx_sh      <= '0;
            first_byte <= 1'b1;
            idle_cnt   <= '0;
        end else begin
            bit_cnt    <= next_bit_cnt;
            rx_sh      <= next_rx_sh;
            tx_sh      <= next_tx_sh;
            first_byte <= next_first_byte;
            idle_cnt   <= next_idle_cnt;
        end
    end
    assign dout_out      = tx_sh[7];
    assign dout_oe_n_out = cs_s || (state == st_power_down);

    byte_fifo #(.width(9), .depth(fifo_depth)) rx_fifo (
        .mclk_in       (mclk_in),
        .resetn_in     (resetn_in),
        .in_valid_in   (byte_done),
        .in_ready_out  (fifo_ready),
        .in_data_in    ({first_byte, rx_sh, din_s}),
        .out_valid_out (rx_valid_out),
        .out_ready_in  (rx_ready_in),
        .out_data_out  (fifo_out)
    );
    assign rx_stall_out   = !fifo_ready;
    assign rx_command_out = fifo_out[8];
    assign rx_byte_out    = fifo_out[7:0];

    // Conversion control and scan sequencer.
    assign sel_mask  = {system_measure_select_in, single_ended_select_high_in,
                        single_ended_select_low_in,
                        differential_select_register_in};
    assign first_sel = next_sel(sel_mask, 5'(NUM_CH - 1));
    assign done      = (state == st_converting) && (cnt == '0);
    always_comb begin
        next_state      = state;
        next_ptr        = ptr;
        next_cnt        = cnt;
        next_single     = single;
        next_sleep_wake = sleep_wake;
        next_ready_cnt  = ready_cnt;
        if (ready_cnt != '0) begin
            next_ready_cnt = ready_cnt - 1'b1;
        end
        case (state)
            st_power_down: begin
                if (!power_down_in) begin
                    next_state      = st_idle;
                    next_sleep_wake = idle_mode_select_in;
                end
            end
            st_idle: begin
                if (power_down_in) begin
                    next_state = st_power_down;
                end else if (start_s || pulse_hit) begin
                    next_state  = st_converting;
                    next_single = !start_s;
                    next_cnt    = first_delay(rate_code_in,
                                              scan_mode_select_in,
                                              sleep_wake);
                end
            end
            st_converting: begin
                if (power_down_in) begin
                    next_state = st_power_down;
                end else if (cnt != '0) begin
                    next_cnt = cnt - 1'b1;
                end else begin
                    next_ready_cnt = READY_LOW;
                    if (scan_mode_select_in) begin
                        next_ptr = next_sel(sel_mask, ptr);
                    end
                    if (start_s && !single) begin
                        next_cnt = cont_cycles;
                    end else begin
                        next_state      = st_idle;
                        next_sleep_wake = idle_mode_select_in;
                    end
                end
            end
            default: next_state = st_power_down;
        endcase
        if (select_write_in && scan_mode_select_in) begin
            next_ptr = first_sel;
        end
        if (!scan_mode_select_in) begin
            next_mux_pos = {1'b0, fixed_pos_in};
            next_mux_neg = {1'b0, fixed_neg_in};
        end else if (ptr < SE_BASE) begin
            next_mux_pos = {1'b0, ptr[2:0], 1'b0};
            next_mux_neg = {1'b0, ptr[2:0], 1'b1};
        end else if (ptr < SYS_BASE) begin
            next_mux_pos = ptr - SE_BASE;
            next_mux_neg = MUX_COMMON;
        end else begin
            next_mux_pos = ptr - SYS_BASE + MUX_SYS;
            next_mux_neg = next_mux_pos;
        end
    end
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state       <= st_idle;
            ptr         <= '0;
            cnt         <= '0;
            single      <= 1'b0;
            sleep_wake  <= 1'b0;
            ready_cnt   <= '0;
            mux_pos_out <= '0;
            mux_neg_out <= '0;
        end else begin
            state       <= next_state;
            ptr         <= next_ptr;
            cnt         <= next_cnt;
            single      <= next_single;
            sleep_wake  <= next_sleep_wake;
            ready_cnt   <= next_ready_cnt;
            mux_pos_out <= next_mux_pos;
            mux_neg_out <= next_mux_neg;
        end
    end
    assign data_ready_n_out  = (ready_cnt == '0);
    assign converting_out    = (state == st_converting);
    assign standby_out       = (state == st_idle) && !sleep_wake;
    assign sleep_out         = (state == st_idle) && sleep_wake;
    assign analog_enable_out = (state != st_power_down);
    assign channel_out       = ptr;

    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_wake;
        state == st_idle && !power_down_in && (start_s || pulse_hit)
            && rate_code_in == RATE_FAST;
    endsequence
    sequence s_ready_pulse;
        !data_ready_n_out [*4] ##1 data_ready_n_out;
    endsequence
    chk_wake_standby: assert property (s_wake ##0 !scan_mode_select_in
        && !sleep_wake |=> cnt == FIX_R3) else $error("standby delay");
    chk_wake_sleep: assert property (s_wake ##0 scan_mode_select_in
        && sleep_wake |=> cnt == SCAN_R3 + SLEEP_EXTRA)
        else $error("sleep delay");
    chk_select_reset: assert property (select_write_in
        && scan_mode_select_in |=> ptr == $past(first_sel))
        else $error("pointer not reset");
    chk_scan_selected: assert property (done && scan_mode_select_in
        && sel_mask != '0 && !select_write_in
        |=> sel_mask[ptr] || $changed(sel_mask)) else $error("bad entry");
    chk_keep_going: assert property (done && start_s && !single
        && !power_down_in |=> converting_out && cnt == cont_cycles)
        else $error("scan stopped");
    chk_stop_idle: assert property (done && !start_s && !power_down_in
        |=> state == st_idle && sleep_out == $past(idle_mode_select_in))
        else $error("idle not entered");
    chk_ready_low: assert property (done |=> s_ready_pulse)
        else $error("data ready pulse");
    chk_power_off: assert property (power_down_in
        |=> !converting_out && !analog_enable_out && dout_oe_n_out)
        else $error("power-down active");
    chk_cs_reset: assert property (cs_s |-> dout_oe_n_out
        ##1 (bit_cnt == '0 && first_byte)) else $error("cs reset");
    chk_timeout_reset: assert property (timeout_hit
        |=> bit_cnt == '0 && first_byte) else $error("timeout reset");
    chk_diff_pair: assert property (scan_mode_select_in && ptr < SE_BASE
        |=> !mux_pos_out[0] && mux_neg_out == mux_pos_out + 5'h01)
        else $error("pair");
    chk_se_common: assert property (scan_mode_select_in
        && ptr >= SE_BASE && ptr < SYS_BASE |=> mux_neg_out == MUX_COMMON)
        else $error("common input");
    chk_fixed_pins: assert property (!scan_mode_select_in
        |=> mux_pos_out == {1'b0, $past(fixed_pos_in)} && !mux_neg_out[4])
        else $error("fixed channel");
    chk_cmd_byte: assert property (byte_done |=> !first_byte)
        else $error("command framing");
    chk_pulse_one: assert property (pulse_hit && state == st_idle
        && !start_s && !power_down_in |=> converting_out && single)
        else $error("pulse convert");
    chk_rx_sample: assert property (rise && !spi_reset
        |=> rx_sh[0] == $past(din_s)) else $error("sample edge");
endmodule

// ===== rtl/scan_adc_pkg.sv
// Purpose: Constants and types for the scan converter control block.
// Assumes: The conversion clock is the block clock, so counts are cycles.
// Notes:   Slowest-rate delays are parameters of the top module.
// Behaviour
// - Three states: converting, idle, power-down.
// - Scan mode select picks auto-scan or fixed.
// - Standby wake delay depends on rate code.
// - Sleep wake adds sixty-four clocks.
// - Select write resets pointer to first selected; the code does so only while scan mode select is high.
// - Twenty-nine scan entries in total.
// - Advance at data ready; continue while start high.
// - Convert selected entries in order, then wrap.
// - Differential entry: even input positive, odd negative.
// - Single-ended entry uses shared common as negative.
// - Fixed mode picks any two analog inputs.
// - Start low: finish channel, enter standby/sleep.
// - Power-down disables analog and digital functions.
// - Chip select high resets and releases interface.
// - Data ready driven regardless of chip select.
// - Sample input rising, change output falling.
// - Idle serial clock timeout resets the interface.
// - Start high: convert from pointer until low.
// - Pulse command converts one channel after byte.
package scan_adc_pkg;
    localparam int          NUM_CH      = 29;
    localparam logic [4:0]  SE_BASE     = 5'h08;
    localparam logic [4:0]  SYS_BASE    = 5'h18;
    localparam logic [4:0]  MUX_COMMON  = 5'h10;
    localparam logic [4:0]  MUX_SYS     = 5'h11;
    localparam logic [1:0]  RATE_FAST   = 2'h3;
    localparam logic [1:0]  RATE_MID    = 2'h2;
    localparam logic [1:0]  RATE_LOW    = 2'h1;
    localparam logic [13:0] FIX_R3      = 14'h0322;
    localparam logic [13:0] SCAN_R3     = 14'h02c4;
    localparam logic [13:0] FIX_R2      = 14'h04a2;
    localparam logic [13:0] SCAN_R2     = 14'h0444;
    localparam logic [13:0] FIX_R1      = 14'h0aa2;
    localparam logic [13:0] SCAN_R1     = 14'h0a44;
    localparam logic [13:0] SLEEP_EXTRA = 14'h0040;
    localparam logic [12:0] TMO_LONG    = 13'h1000;
    localparam logic [12:0] TMO_SHORT   = 13'h0100;
    localparam logic [2:0]  BYTE_LAST   = 3'h7;
    localparam logic [3:0]  READY_LOW   = 4'h4;
    localparam logic [3:0]  SYNC_RST    = 4'h4;
    typedef enum logic [1:0] {
        st_power_down,
        st_idle,
        st_converting
    } op_state_t;
endpackage

// ===== verif/spi_host_model.sv
// Purpose: Host master model that drives chip select, serial clock and data.
// Assumes: The serial clock period is 80 ns and the clock idles low.
// Notes:   The return line is sampled on each rising serial clock edge.
`timescale 1ns/1ps
module spi_host_model (
    output logic      cs_n_out,
    output logic      sclk_out,
    output logic      din_out,
    input  wire logic dout_in,
    input  wire logic dout_oe_n_in
);
    logic [7:0] got;
    // A released return line shows the inverse of the last bit taken.
    wire        line = dout_oe_n_in ? ~got[0] : dout_in;

    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        din_out  = 1'b0;
        got      = 8'h00;
    end

    // Sends the top n bits of b, MSB first, so a byte can be cut short; the return line is shifted into got at each bit.
    task automatic shift(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            din_out = b[i];
            #40;
            sclk_out = 1'b1;
            got = {got[6:0], line};
            #40;
            sclk_out = 1'b0;
        end
    endtask

    // Chip select is set to lvl, the data line is toggled, then both are held for 200 ns.
    task automatic select(input logic lvl);
        cs_n_out = lvl;
        din_out  = ~din_out;
        #200;
    endtask
endmodule

// ===== verif/testbench.sv
// Purpose: Self-checking bench for the scan converter control block.
// Assumes: The host model drives the serial pins; the bench the rest.
// Notes:   Slowest-rate and continuous counts are shortened.
`timescale 1ns/1ps
module testbench;
    typedef struct {logic [1:0] r; logic s; logic z; int n;} row_t;
    logic       mclk_in = 1'b0;
    logic       resetn_in, start_in, power_down_in, scan_mode_select_in;
    logic       idle_mode_select_in, interface_timeout_select_in;
    logic       select_write_in, rx_ready_in;
    logic [1:0] rate_code_in;
    logic [7:0] differential_select_register_in, tx_byte_in;
    logic [7:0] single_ended_select_low_in, single_ended_select_high_in;
    logic [4:0] system_measure_select_in;
    logic [3:0] fixed_pos_in, fixed_neg_in;
    wire        cs_n_in, sclk_in, din_in, dout_out, dout_oe_n_out;
    wire        data_ready_n_out, converting_out, standby_out, sleep_out;
    wire        analog_enable_out, rx_command_out, rx_valid_out, rx_stall_out;
    wire  [4:0] channel_out, mux_pos_out, mux_neg_out;
    wire  [7:0] rx_byte_out;
    int         fails = 0, tests_run = 0, falls = 0, k, n;
    row_t       rows [10] = '{'{2'h3, 1'b0, 1'b0, 802}, '{2'h3, 1'b1, 1'b0, 708},
        '{2'h3, 1'b0, 1'b1, 866}, '{2'h3, 1'b1, 1'b1, 772},
        '{2'h2, 1'b0, 1'b0, 1186}, '{2'h2, 1'b1, 1'b1, 1156},
        '{2'h1, 1'b0, 1'b0, 2722}, '{2'h1, 1'b1, 1'b1, 2692},
        '{2'h0, 1'b0, 1'b0, 40}, '{2'h0, 1'b1, 1'b1, 94}};
    logic [15:0] seq [4] = '{{1'b0, 5'd8, 5'd0, 5'd16},
        {1'b0, 5'd23, 5'd15, 5'd16}, {1'b0, 5'd26, 5'd19, 5'd19},
        {1'b0, 5'd3, 5'd6, 5'd7}};

    scan_adc_ctrl #(
        .slow_fixed_cycles(14'h0028),
        .slow_scan_cycles (14'h001e),
        .cont_cycles      (14'h0020)
    ) scan_adc_ctrl_i (
        .mclk_in, .resetn_in, .start_in, .power_down_in, .scan_mode_select_in,
        .idle_mode_select_in, .interface_timeout_select_in, .rate_code_in,
        .differential_select_register_in, .single_ended_select_low_in,
        .single_ended_select_high_in, .system_measure_select_in,
        .select_write_in, .fixed_pos_in, .fixed_neg_in, .cs_n_in, .sclk_in,
        .din_in, .tx_byte_in, .rx_ready_in, .dout_out, .dout_oe_n_out,
        .data_ready_n_out, .converting_out, .standby_out, .sleep_out,
        .analog_enable_out, .channel_out, .mux_pos_out, .mux_neg_out,
        .rx_byte_out, .rx_command_out, .rx_valid_out, .rx_stall_out);

    spi_host_model spi_host_model_i (
        .cs_n_out(cs_n_in), .sclk_out(sclk_in), .din_out(din_in),
        .dout_in(dout_out), .dout_oe_n_in(dout_oe_n_out));

    always #4 mclk_in = ~mclk_in;
    always @(negedge data_ready_n_out) falls++;

    task automatic chk(input string w, input logic [15:0] e,
                       input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic cyc(input int c);
        repeat (c) @(negedge mclk_in);
    endtask

    task automatic wait_dr(output int c);
        c = 0;
        while (data_ready_n_out === 1'b0) begin
            @(posedge mclk_in);
            #1;
        end
        do begin
            @(posedge mclk_in);
            #1 c++;
        end while (data_ready_n_out !== 1'b0 && c < 20000);
    endtask

    task automatic wait_idle();
        for (int t = 0; t < 4000 && converting_out === 1'b1; t++) cyc(1);
        cyc(2);
    endtask

    task automatic pop(input logic [7:0] b, input logic c);
        cyc(2);
        chk("rx_valid", 16'h1, 16'(rx_valid_out));
        chk("rx_byte", 16'(b), 16'(rx_byte_out));
        chk("rx_command", 16'(c), 16'(rx_command_out));
        rx_ready_in = 1'b1;
        cyc(1);
        rx_ready_in = 1'b0;
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #600000;
        fails++;
        $display("ERROR watchdog expected finish seen hang");
        summarize();
    end

    initial begin
        {resetn_in, start_in, power_down_in, select_write_in} = 4'h0;
        {scan_mode_select_in, idle_mode_select_in, rx_ready_in} = 3'h0;
        interface_timeout_select_in = 1'b0;
        rate_code_in = 2'h3;
        differential_select_register_in = 8'h01;
        single_ended_select_low_in = 8'h00;
        single_ended_select_high_in = 8'h00;
        system_measure_select_in = 5'h00;
        fixed_pos_in = 4'h5;
        fixed_neg_in = 4'hc;
        tx_byte_in = 8'ha5;
        repeat (5) @(posedge mclk_in);
        chk("reset", 16'h4611, {converting_out, standby_out, 3'h0, data_ready_n_out,
            dout_oe_n_out, rx_valid_out, 3'h0, analog_enable_out, 4'h1});
        cyc(1);
        resetn_in = 1'b1;
        for (int i = 0; i < 10; i++) begin
            cyc(3);
            fixed_pos_in = 4'(i + 4);
            rate_code_in = rows[i].r;
            scan_mode_select_in = rows[i].s;
            start_in = 1'b1;
            wait_dr(k);
            chk("first_ready", 16'(rows[i].n + 4), 16'(k));
            if (!rows[i].s)
                chk("fixed_mux", {3'h0, 5'(i + 4), 8'h0c},
                    {3'h0, mux_pos_out, 3'h0, mux_neg_out});
            cyc(1);
            idle_mode_select_in = (i < 9) ? rows[i + 1].z : 1'b0;
            start_in = 1'b0;
            n = falls;
            wait_idle();
            chk("stop_ready", 16'h1, 16'(falls - n));
            chk("idle_kind", 16'(idle_mode_select_in), 16'(sleep_out));
        end
        scan_mode_select_in = 1'b1;
        rate_code_in = 2'h3;
        differential_select_register_in = 8'h08;
        single_ended_select_low_in = 8'h01;
        single_ended_select_high_in = 8'h80;
        system_measure_select_in = 5'h04;
        select_write_in = 1'b1;
        cyc(1);
        select_write_in = 1'b0;
        cyc(2);
        chk("first_ptr", 16'h3, 16'(channel_out));
        start_in = 1'b1;
        for (int j = 0; j < 4; j++) begin
            wait_dr(k);
            cyc(2);
            chk("scan", seq[j], {1'b0, channel_out, mux_pos_out, mux_neg_out});
        end
        start_in = 1'b0;
        wait_idle();
        chk("stop_ptr", 16'd8, 16'(channel_out));
        select_write_in = 1'b1;
        cyc(1);
        select_write_in = 1'b0;
        cyc(2);
        chk("reload_ptr", 16'h3, 16'(channel_out));
        spi_host_model_i.select(1'b0);
        chk("oe_n_low", 16'h0, 16'(dout_oe_n_out));
        spi_host_model_i.shift(8'h80, 8);
        pop(8'h80, 1'b1);
        chk("dout", 16'ha5, 16'(spi_host_model_i.got));
        wait_dr(k);
        wait_idle();
        chk("pulse", 16'h0108, {7'h0, standby_out, 3'h0, channel_out});
        spi_host_model_i.shift(8'h5a, 8);
        pop(8'h5a, 1'b0);
        chk("dout_next", 16'ha5, 16'(spi_host_model_i.got));
        tx_byte_in = 8'h3c;
        spi_host_model_i.shift(8'hf0, 4);
        spi_host_model_i.select(1'b1);
        chk("oe_n_high", 16'h1, 16'(dout_oe_n_out));
        spi_host_model_i.select(1'b0);
        spi_host_model_i.shift(8'h3c, 8);
        pop(8'h3c, 1'b1);
        chk("dout_cs", 16'h3c, 16'(spi_host_model_i.got));
        spi_host_model_i.shift(8'ha0, 4);
        cyc(300);
        spi_host_model_i.shift(8'h50, 4);
        pop(8'ha5, 1'b0);
        interface_timeout_select_in = 1'b1;
        spi_host_model_i.shift(8'h90, 4);
        cyc(100);
        spi_host_model_i.shift(8'h60, 4);
        pop(8'h96, 1'b0);
        spi_host_model_i.shift(8'hff, 3);
        cyc(300);
        spi_host_model_i.shift(8'hc3, 8);
        pop(8'hc3, 1'b1);
        for (int j = 1; j < 6; j++) spi_host_model_i.shift(8'(8'h11 * j), 8);
        cyc(2);
        chk("fifo_full", 16'h1, 16'(rx_stall_out));
        for (int j = 1; j < 5; j++) pop(8'(8'h11 * j), 1'b0);
        chk("fifo_empty", 16'h0, 16'(rx_valid_out));
        power_down_in = 1'b1;
        start_in = 1'b1;
        cyc(20);
        chk("power_down", 16'h1, 16'({analog_enable_out, converting_out,
            standby_out, dout_oe_n_out}));
        power_down_in = 1'b0;
        cyc(10);
        chk("wake", 16'h1, 16'(analog_enable_out));
        summarize();
    end
endmodule
